/* hdl/mscr_pkg.sv */
package mscr_pkg;
	// ==========================================================
	// bus geometry: register index is byte address divided by four
	localparam int ADDR_W = 11;
	localparam int IDX_W = 9;
	localparam int LEN_W = 13;
	// ==========================================================
	// register indices
	localparam logic [8:0] IDX_LOAD_CMD = 9'h12e;
	localparam logic [8:0] IDX_TX_STATUS = 9'h132;
	localparam logic [8:0] IDX_RX_STATUS = 9'h133;
	localparam logic [8:0] IDX_CFG0 = 9'h135;
	localparam logic [8:0] IDX_CFG1 = 9'h136;
	localparam logic [8:0] IDX_TUNE_A = 9'h180;
	localparam logic [8:0] IDX_TUNE_B = 9'h182;
	localparam logic [8:0] IDX_TUNE_T = 9'h184;
	// ==========================================================
	// field positions
	localparam int TX_EXCESS_COLLISION_FLAG = 5;
	localparam int TX_LATE_COLLISION_FLAG = 4;
	localparam int TX_CRS = 3;
	localparam int TX_JBR = 2;
	localparam int TX_EMPTY = 1;
	localparam int TX_FULL = 0;
	localparam int RX_WAKE = 7;
	localparam int RX_BUFF = 6;
	localparam int RX_LINK = 5;
	localparam int RX_RUNT = 4;
	localparam int RX_LONG = 3;
	localparam int RX_CRC = 2;
	localparam int RX_ALIGN = 1;
	localparam int RX_OK = 0;
	localparam int C0_LAMP_DRV = 7;
	localparam int C0_TUNE_EN = 6;
	localparam int C0_LINKDOWN_POWER_SAVE_N = 3;
	localparam int C0_MEDIUM = 2;
	localparam int C0_SCHEME = 0;
	localparam int C1_BCAST = 6;
	localparam int C1_MCAST = 5;
	localparam int C1_UCAST = 4;
	localparam int C1_JOIN1 = 1;
	localparam int C1_JOIN0 = 0;
	localparam int LOAD_GO = 0;
	localparam int DA_GROUP = 40;
	// ==========================================================
	// reset values, write masks, frame limits
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] CFG0_RST = 8'h00;
	localparam logic [7:0] CFG1_RST = 8'h00;
	localparam logic [15:0] TUNE_RST = 16'h0000;
	localparam logic [7:0] CFG0_WMASK = 8'hcf;
	localparam logic [7:0] CFG1_WMASK = 8'h73;
	localparam logic [12:0] RUNT_MIN_BYTES = 13'h0040;
	localparam logic [12:0] LONG_MAX_BYTES = 13'h1000;
	localparam logic [47:0] BCAST_DA = 48'hffff_ffff_ffff;
	typedef enum logic [1:0] {LD_IDLE, LD_REQ, LD_APPLY} mscr_load_state_t;
endpackage

/* hdl/mscr_load_if.sv */
`timescale 1ns/100ps
interface mscr_load_if;
	logic start;
	logic busy;
	logic apply;
	logic [1:0] lamp_scheme;
	logic [15:0] tune_a;
	logic [15:0] tune_b;
	logic [15:0] tune_t;
	modport regs (output start, input busy, apply, lamp_scheme, tune_a, tune_b, tune_t);
	modport loader (input start, output busy, apply, lamp_scheme, tune_a, tune_b, tune_t);
endinterface

/* hdl/mscr_eeprom_load_cmd.sv */
`timescale 1ns/100ps
module mscr_eeprom_load_cmd import mscr_pkg::*; (
	input logic pclk,
	input logic presetn,
	mscr_load_if.loader lif,
	output logic ee_req,
	input logic ee_ack,
	input logic [1:0] ee_lamp_scheme,
	input logic [15:0] ee_tuning_a,
	input logic [15:0] ee_tuning_b,
	input logic [15:0] ee_timing
);
	mscr_load_state_t state;

	// ==========================================================
	// sequencer: request, wait for the loader, apply once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= LD_IDLE;
		end else begin
			case (state)
				LD_IDLE: if (lif.start) state <= LD_REQ;
				LD_REQ: if (ee_ack) state <= LD_APPLY;
				LD_APPLY: state <= LD_IDLE;
				default: state <= LD_IDLE;
			endcase
		end
	end

	// captured with the acknowledge so the loader may drop its data after it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lif.lamp_scheme <= 2'h0;
			lif.tune_a <= TUNE_RST;
			lif.tune_b <= TUNE_RST;
			lif.tune_t <= TUNE_RST;
		end else if (state == LD_REQ && ee_ack) begin
			lif.lamp_scheme <= ee_lamp_scheme;
			lif.tune_a <= ee_tuning_a;
			lif.tune_b <= ee_tuning_b;
			lif.tune_t <= ee_timing;
		end
	end

	assign ee_req = (state == LD_REQ);
	assign lif.apply = (state == LD_APPLY);
	assign lif.busy = (state != LD_IDLE);

	// ==========================================================
	// checks
	a_ack_to_apply: assert property (@(posedge pclk) disable iff (!presetn)
		ee_req && ee_ack |=> lif.apply && lif.tune_a == $past(ee_tuning_a))
		else $error("reload not applied after loader acknowledge");
	a_load_self_clear: assert property (@(posedge pclk) disable iff (!presetn)
		lif.apply |=> !lif.busy)
		else $error("load command did not clear after completion");
	c_load_done: cover property (@(posedge pclk) disable iff (!presetn) lif.apply);
endmodule

/* hdl/mscr_regs.sv */
// Overview of operation
// - tx status bit 5 flags excessive-collision abort, bit 4 late collision, read-only.
// - tx status bit 3 flags carrier loss, bit 2 jabber timeout.
// - tx status bit 1 shows buffer empty, bit 0 buffer full.
// - tx status returns to default after a read or interrupt endpoint access.
// - rx status bit 7 flags a detected wake-up event.
// - rx status bit 6 flags full rx buffer, bit 5 link change.
// - rx status bit 4 flags a frame shorter than 64 bytes.
// - rx status bit 3 flags a frame longer than 4 kilobytes.
// - rx status bit 2 flags bad frame check, bit 1 alignment error.
// - rx status bit 0 flags a frame received without error.
// - rx status returns to default after a read or interrupt endpoint access.
// - config0 bit 7 low forces lamps high during suspend; resets low.
// - config0 bit 6 gates writes to the three tuning words.
// - every auto-load reloads the tuning words from the eeprom.
// - config0 bit 3 low with link down powers down part of front end.
// - config0 bit 2 one forces MII; zero auto-detects on internal link.
// - reading config0 bit 2 shows whether the MAC sits on external MII.
// - config0 bits 1-0 pick lamp scheme, default from eeprom auto-load.
// - config1 bit 6 wakes on good broadcast frame when remote wakeup enabled.
// - config1 bit 5 wakes on good hashed multicast frame when enabled.
// - config1 bit 4 wakes on good frame addressed to station address.
// - config1 bits 0/1 join pattern masks 1+2 / 3+4, disabling those frames.
// - the load command copies eeprom into registers and clears itself when done.
`timescale 1ns/100ps
module mscr_regs import mscr_pkg::*; #(
	parameter int LAMP_N = 4
) (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [ADDR_W-1:0] paddr,
	input logic [31:0] pwdata,
	input logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input logic tx_excess_collision,
	input logic tx_late_collision,
	input logic tx_carrier_lost,
	input logic tx_jabber_timeout,
	input logic tx_buf_empty,
	input logic tx_buf_full,
	input logic rx_buf_full,
	input logic rx_frame_done,
	input logic [LEN_W-1:0] rx_frame_len,
	input logic rx_crc_error,
	input logic rx_align_error,
	input logic [47:0] dest_id,
	input logic [47:0] station_address,
	input logic mcast_hash_hit,
	input logic wake_pattern_hit,
	input logic link_up,
	input logic interrupt_endpoint,
	input logic remote_wakeup_en,
	input logic usb_suspend,
	input logic [LAMP_N-1:0] lamp_in,
	output logic [LAMP_N-1:0] lamp_out,
	output logic afe_powerdown,
	output logic internal_phy_off,
	output logic mac_on_mii,
	output logic [1:0] lamp_scheme,
	output logic [15:0] phy_tuning_word_a,
	output logic [15:0] phy_tuning_word_b,
	output logic [15:0] timing_tuning_word,
	output logic [1:0] pattern_join,
	output logic [3:0] pattern_enable,
	output logic wake_signal,
	output logic ee_req,
	input logic ee_ack,
	input logic [1:0] ee_lamp_scheme,
	input logic [15:0] ee_tuning_a,
	input logic [15:0] ee_tuning_b,
	input logic [15:0] ee_timing
);
	logic [7:0] tx_event_status;
	logic [7:0] rx_event_status;
	logic [7:0] config_zero;
	logic [7:0] config_one;
	logic [7:0] tx_set;
	logic [7:0] rx_set;
	logic [7:0] tx_clr;
	logic [7:0] rx_clr;
	logic [7:0] next_tx_status;
	logic [7:0] next_rx_status;
	logic link_prev;
	logic link_armed;
	logic rx_good;
	logic wake_hit;
	logic setup_ph;
	logic acc_rd;
	logic acc_wr;
	logic [IDX_W-1:0] acc_idx;
	logic tune_wr;

	mscr_load_if lif();

	mscr_eeprom_load_cmd u_load (
		.pclk(pclk),
		.presetn(presetn),
		.lif(lif),
		.ee_req(ee_req),
		.ee_ack(ee_ack),
		.ee_lamp_scheme(ee_lamp_scheme),
		.ee_tuning_a(ee_tuning_a),
		.ee_tuning_b(ee_tuning_b),
		.ee_timing(ee_timing)
	);

	// ==========================================================
	// bus decode
	function automatic logic [IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:2];
	endfunction

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		logic [IDX_W-1:0] i;
		i = idx_of(a);
		return (a[1:0] == 2'h0) && (i == IDX_LOAD_CMD || i == IDX_TX_STATUS ||
			i == IDX_RX_STATUS || i == IDX_CFG0 || i == IDX_CFG1 ||
			i == IDX_TUNE_A || i == IDX_TUNE_B || i == IDX_TUNE_T);
	endfunction

	assign setup_ph = psel && !penable;
	assign acc_idx = idx_of(paddr);
	assign acc_rd = psel && penable && !pwrite && is_mapped(paddr);
	assign acc_wr = psel && penable && pwrite && is_mapped(paddr);
	// zero wait states: read data is fetched in the setup cycle
	assign pready = 1'b1;
	assign pslverr = psel && penable && !is_mapped(paddr);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_ph) begin
			prdata <= 32'h0000_0000;
			if (is_mapped(paddr) && !pwrite) begin
				case (idx_of(paddr))
					IDX_LOAD_CMD: prdata[LOAD_GO] <= lif.busy;
					IDX_TX_STATUS: prdata[7:0] <= tx_event_status;
					IDX_RX_STATUS: prdata[7:0] <= rx_event_status;
					IDX_CFG0: prdata[7:0] <= {config_zero[7:3], mac_on_mii,
						config_zero[1:0]};
					IDX_CFG1: prdata[7:0] <= config_one;
					IDX_TUNE_A: prdata[15:0] <= phy_tuning_word_a;
					IDX_TUNE_B: prdata[15:0] <= phy_tuning_word_b;
					IDX_TUNE_T: prdata[15:0] <= timing_tuning_word;
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ==========================================================
	// event capture
	assign rx_good = rx_frame_done && !rx_crc_error && !rx_align_error &&
		rx_frame_len >= RUNT_MIN_BYTES && rx_frame_len <= LONG_MAX_BYTES;
	assign wake_hit = remote_wakeup_en && (wake_pattern_hit || (rx_good && (
		(config_one[C1_BCAST] && dest_id == BCAST_DA) ||
		(config_one[C1_MCAST] && dest_id[DA_GROUP] && mcast_hash_hit) ||
		(config_one[C1_UCAST] && dest_id == station_address))));

	always_comb begin
		tx_set = STATUS_RST;
		tx_set[TX_EXCESS_COLLISION_FLAG] = tx_excess_collision;
		tx_set[TX_LATE_COLLISION_FLAG] = tx_late_collision;
		tx_set[TX_CRS] = tx_carrier_lost;
		tx_set[TX_JBR] = tx_jabber_timeout;
		tx_set[TX_EMPTY] = tx_buf_empty;
		tx_set[TX_FULL] = tx_buf_full;
		rx_set = STATUS_RST;
		rx_set[RX_WAKE] = wake_hit;
		rx_set[RX_BUFF] = rx_buf_full;
		rx_set[RX_LINK] = link_armed && link_up != link_prev;
		rx_set[RX_RUNT] = rx_frame_done && rx_frame_len < RUNT_MIN_BYTES;
		rx_set[RX_LONG] = rx_frame_done && rx_frame_len > LONG_MAX_BYTES;
		rx_set[RX_CRC] = rx_frame_done && rx_crc_error;
		rx_set[RX_ALIGN] = rx_frame_done && rx_align_error;
		rx_set[RX_OK] = rx_good;
	end

	// a read clears only what it returned, so a flag raised between setup
	// and access survives for the next read; new events beat the clear
	always_comb begin
		tx_clr = 8'h00;
		rx_clr = 8'h00;
		if (interrupt_endpoint) begin
			tx_clr = 8'hff;
			rx_clr = 8'hff;
		end else if (acc_rd && acc_idx == IDX_TX_STATUS) begin
			tx_clr = prdata[7:0];
		end else if (acc_rd && acc_idx == IDX_RX_STATUS) begin
			rx_clr = prdata[7:0];
		end
		next_tx_status = (tx_event_status & ~tx_clr) | tx_set;
		next_rx_status = (rx_event_status & ~rx_clr) | rx_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_event_status <= STATUS_RST;
			rx_event_status <= STATUS_RST;
		end else begin
			tx_event_status <= next_tx_status;
			rx_event_status <= next_rx_status;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_prev <= 1'b0;
			link_armed <= 1'b0;
			wake_signal <= 1'b0;
		end else begin
			// the first edge after reset only learns the link level, so a link
			// that was already up is not reported as a change
			link_prev <= link_up;
			link_armed <= 1'b1;
			wake_signal <= wake_hit;
		end
	end

	// ==========================================================
	// configuration and tuning registers
	assign lif.start = acc_wr && acc_idx == IDX_LOAD_CMD && pstrb[0] &&
		pwdata[LOAD_GO] && !lif.busy;
	assign tune_wr = acc_wr && config_zero[C0_TUNE_EN];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_zero <= CFG0_RST;
			config_one <= CFG1_RST;
		end else begin
			if (acc_wr && pstrb[0] && acc_idx == IDX_CFG0) begin
				config_zero <= pwdata[7:0] & CFG0_WMASK;
			end
			if (acc_wr && pstrb[0] && acc_idx == IDX_CFG1) begin
				config_one <= pwdata[7:0] & CFG1_WMASK;
			end
			if (lif.apply) begin
				config_zero[C0_SCHEME+:2] <= lif.lamp_scheme;
			end
		end
	end

	// tuning words: byte lanes 0 and 1; the reload wins over a bus write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phy_tuning_word_a <= TUNE_RST;
			phy_tuning_word_b <= TUNE_RST;
			timing_tuning_word <= TUNE_RST;
		end else if (lif.apply) begin
			phy_tuning_word_a <= lif.tune_a;
			phy_tuning_word_b <= lif.tune_b;
			timing_tuning_word <= lif.tune_t;
		end else if (tune_wr) begin
			for (int b = 0; b < 2; b++) begin
				if (pstrb[b] && acc_idx == IDX_TUNE_A) phy_tuning_word_a[8*b+:8] <= pwdata[8*b+:8];
				if (pstrb[b] && acc_idx == IDX_TUNE_B) phy_tuning_word_b[8*b+:8] <= pwdata[8*b+:8];
				if (pstrb[b] && acc_idx == IDX_TUNE_T) timing_tuning_word[8*b+:8] <= pwdata[8*b+:8];
			end
		end
	end

	// ==========================================================
	// outputs steered by configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lamp_out <= '1;
			afe_powerdown <= 1'b0;
			mac_on_mii <= 1'b0;
			pattern_enable <= 4'hf;
		end else begin
			// high turns a lamp off; scheme logic outside supplies lamp_in
			lamp_out <= (usb_suspend && !config_zero[C0_LAMP_DRV]) ? '1 : lamp_in;
			afe_powerdown <= !config_zero[C0_LINKDOWN_POWER_SAVE_N] && !link_up;
			mac_on_mii <= config_zero[C0_MEDIUM] || !link_up;
			pattern_enable <= {{2{!config_one[C1_JOIN1]}}, {2{!config_one[C1_JOIN0]}}};
		end
	end

	assign internal_phy_off = config_zero[C0_MEDIUM];
	assign lamp_scheme = config_zero[C0_SCHEME+:2];
	assign pattern_join = {config_one[C1_JOIN1], config_one[C1_JOIN0]};

	// ==========================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_tx_collision: assert property (tx_excess_collision |=> tx_event_status[TX_EXCESS_COLLISION_FLAG] ##1
		(tx_event_status[TX_EXCESS_COLLISION_FLAG] || $past(interrupt_endpoint) ||
		$past(acc_rd && acc_idx == IDX_TX_STATUS)))
		else $error("excess collision flag not held");
	a_tx_late: assert property (tx_late_collision |=> tx_event_status[TX_LATE_COLLISION_FLAG])
		else $error("late collision flag not set");
	a_tx_carrier: assert property (tx_carrier_lost |=> tx_event_status[TX_CRS])
		else $error("carrier lost flag not set");
	a_tx_jabber: assert property (tx_jabber_timeout |=> tx_event_status[TX_JBR])
		else $error("jabber timeout flag not set");
	a_tx_full: assert property (tx_buf_full |=> tx_event_status[TX_FULL])
		else $error("tx full flag not set");
	a_ep_clears: assert property (interrupt_endpoint && tx_set == 8'h00 && rx_set == 8'h00
		|=> tx_event_status == STATUS_RST && rx_event_status == STATUS_RST)
		else $error("endpoint access did not clear status");
	a_read_clears: assert property (acc_rd && acc_idx == IDX_TX_STATUS && tx_set == 8'h00
		&& !interrupt_endpoint |=> (tx_event_status & $past(prdata[7:0])) == 8'h00)
		else $error("read did not clear returned tx flags");
	a_wake_flag: assert property (wake_hit |=> wake_signal && rx_event_status[RX_WAKE])
		else $error("wake event not flagged");
	a_rx_buff: assert property (rx_buf_full |=> rx_event_status[RX_BUFF])
		else $error("rx buffer full not flagged");
	a_link_change: assert property (link_armed && $changed(link_up)
		|=> rx_event_status[RX_LINK])
		else $error("link change not flagged");
	a_rx_runt: assert property (rx_frame_done && rx_frame_len < RUNT_MIN_BYTES
		|=> rx_event_status[RX_RUNT] && !rx_event_status[RX_OK] || $past(rx_event_status[RX_OK]))
		else $error("runt frame not flagged");
	a_rx_long: assert property (rx_frame_done && rx_frame_len > LONG_MAX_BYTES
		|=> rx_event_status[RX_LONG])
		else $error("long frame not flagged");
	a_rx_crc: assert property (rx_frame_done && rx_crc_error |=> rx_event_status[RX_CRC])
		else $error("crc error not flagged");
	a_rx_align: assert property (rx_frame_done && rx_align_error |=> rx_event_status[RX_ALIGN])
		else $error("alignment error not flagged");
	a_rx_good: assert property (rx_good |=> rx_event_status[RX_OK])
		else $error("good frame not flagged");
	a_lamp_suspend: assert property (usb_suspend && !config_zero[C0_LAMP_DRV]
		|=> lamp_out == {LAMP_N{1'b1}})
		else $error("lamps not forced off in suspend");
	a_tune_block: assert property (acc_wr && !config_zero[C0_TUNE_EN] && !lif.apply
		|=> $stable(phy_tuning_word_a) && $stable(timing_tuning_word))
		else $error("tuning word changed while writes blocked");
	a_power_save: assert property (!config_zero[C0_LINKDOWN_POWER_SAVE_N] && !link_up |=> afe_powerdown)
		else $error("front end not powered down on link loss");
	a_medium_auto: assert property (!config_zero[C0_MEDIUM] && link_up |=> !mac_on_mii)
		else $error("auto-detect left internal phy with link");
	a_pattern_join: assert property (config_one[C1_JOIN0] |=> pattern_enable[1:0] == 2'h0)
		else $error("joined pattern frames not disabled");
	a_reserved_zero: assert property (config_zero[5:4] == 2'h0 && config_one[7] == 1'b0
		&& config_one[3:2] == 2'h0 && tx_event_status[7:6] == 2'h0)
		else $error("reserved bit set");

	c_tx_read_clear: cover property (acc_rd && acc_idx == IDX_TX_STATUS && prdata[7:0] != 8'h00);
	c_wake: cover property (wake_signal);
	c_tune_write: cover property (tune_wr && acc_idx == IDX_TUNE_A);
	c_ep_clear: cover property (interrupt_endpoint && rx_event_status != 8'h00);
endmodule

/* tb/mscr_ee_model.sv */
`timescale 1ns/100ps
// ==========================================================
// serial eeprom loader stand-in: answers a load request DELAY+1 cycles after it rises
module mscr_ee_model #(
	parameter int DELAY = 5,
	parameter logic [1:0] SCHEME = 2'b10,
	parameter logic [15:0] WORD_A = 16'h3c5a,
	parameter logic [15:0] WORD_B = 16'h0f1e,
	parameter logic [15:0] WORD_T = 16'h7788
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ee_req,
	output logic ee_ack,
	output logic [1:0] ee_lamp_scheme,
	output logic [15:0] ee_tuning_a,
	output logic [15:0] ee_tuning_b,
	output logic [15:0] ee_timing
);
	logic [7:0] cnt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 8'h00;
			ee_ack <= 1'b0;
		end else if (ee_req && !ee_ack && cnt == DELAY[7:0]) begin
			ee_ack <= 1'b1;
			cnt <= 8'h00;
		end else begin
			ee_ack <= 1'b0;
			cnt <= ee_req ? cnt + 8'h01 : 8'h00;
		end
	end

	// data is only valid with the acknowledge; otherwise show the inverse so a
	// capture on the wrong cycle cannot pass by luck
	assign ee_lamp_scheme = ee_ack ? SCHEME : ~SCHEME;
	assign ee_tuning_a = ee_ack ? WORD_A : ~WORD_A;
	assign ee_tuning_b = ee_ack ? WORD_B : ~WORD_B;
	assign ee_timing = ee_ack ? WORD_T : ~WORD_T;
endmodule

/* tb/mac_status_config_regs_tb.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
module mac_status_config_regs_tb import mscr_pkg::*; ;
	localparam logic [47:0] STA = 48'h0200_1122_3344;
	localparam logic [ADDR_W-1:0] A_LD = {IDX_LOAD_CMD, 2'b00};
	localparam logic [ADDR_W-1:0] A_TX = {IDX_TX_STATUS, 2'b00};
	localparam logic [ADDR_W-1:0] A_RX = {IDX_RX_STATUS, 2'b00};
	localparam logic [ADDR_W-1:0] A_C0 = {IDX_CFG0, 2'b00};
	localparam logic [ADDR_W-1:0] A_C1 = {IDX_CFG1, 2'b00};
	localparam logic [ADDR_W-1:0] A_TA = {IDX_TUNE_A, 2'b00};
	typedef struct packed {
		logic [5:0] tx;
		logic fd;
		logic [12:0] len;
		logic crc;
		logic al;
		logic [7:0] txe;
		logic [7:0] rxe;
	} mscr_row_t;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [5:0] tx_ev = '0;
	logic rxbf = 0, fdone = 0, crc = 0, al = 0, hash = 1, wpat = 0, link = 0, iep = 0;
	logic rwe = 0, susp = 1, err, afe, phy_off, on_mii, wake, ee_req, ee_ack;
	logic [LEN_W-1:0] flen = 13'h0064;
	logic [47:0] da = '0;
	logic [3:0] lamp_in = 4'ha, lamp_out, pen;
	logic [1:0] scheme, pjoin, ee_s;
	logic [15:0] ta, tb, tt, ee_a, ee_b, ee_t;
	int error_cnt = 0, tests_run = 0;
	logic [47:0] das [3] = '{BCAST_DA, 48'h0100_0000_0001, STA};
	mscr_row_t rows [12] = '{
		'{6'h20, 0, 0, 0, 0, 8'h20, 8'h00}, '{6'h10, 0, 0, 0, 0, 8'h10, 8'h00},
		'{6'h08, 0, 0, 0, 0, 8'h08, 8'h00}, '{6'h04, 0, 0, 0, 0, 8'h04, 8'h00},
		'{6'h02, 0, 0, 0, 0, 8'h02, 8'h00}, '{6'h01, 0, 0, 0, 0, 8'h01, 8'h00},
		'{6'h00, 1, 64, 0, 0, 8'h00, 8'h01}, '{6'h00, 1, 63, 0, 0, 8'h00, 8'h10},
		'{6'h00, 1, 4096, 0, 0, 8'h00, 8'h01}, '{6'h00, 1, 4097, 0, 0, 8'h00, 8'h08},
		'{6'h00, 1, 100, 1, 0, 8'h00, 8'h04}, '{6'h00, 1, 100, 0, 1, 8'h00, 8'h02}};

	mscr_regs #(.LAMP_N(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_excess_collision(tx_ev[5]),
		.tx_late_collision(tx_ev[4]), .tx_carrier_lost(tx_ev[3]),
		.tx_jabber_timeout(tx_ev[2]), .tx_buf_empty(tx_ev[1]), .tx_buf_full(tx_ev[0]),
		.rx_buf_full(rxbf), .rx_frame_done(fdone), .rx_frame_len(flen), .rx_crc_error(crc),
		.rx_align_error(al), .dest_id(da), .station_address(STA), .mcast_hash_hit(hash),
		.wake_pattern_hit(wpat), .link_up(link), .interrupt_endpoint(iep),
		.remote_wakeup_en(rwe), .usb_suspend(susp), .lamp_in(lamp_in), .lamp_out(lamp_out),
		.afe_powerdown(afe), .internal_phy_off(phy_off), .mac_on_mii(on_mii),
		.lamp_scheme(scheme), .phy_tuning_word_a(ta), .phy_tuning_word_b(tb),
		.timing_tuning_word(tt), .pattern_join(pjoin), .pattern_enable(pen),
		.wake_signal(wake), .ee_req(ee_req), .ee_ack(ee_ack), .ee_lamp_scheme(ee_s),
		.ee_tuning_a(ee_a), .ee_tuning_b(ee_b), .ee_timing(ee_t));
	mscr_ee_model #(.DELAY(5)) ee (.pclk(pclk), .presetn(presetn), .ee_req(ee_req),
		.ee_ack(ee_ack), .ee_lamp_scheme(ee_s), .ee_tuning_a(ee_a), .ee_tuning_b(ee_b),
		.ee_timing(ee_t));

	initial begin
		forever #12.5 pclk = ~pclk;
	end

	task end_of_test;
		if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==========================================================
	// apb master: holds the request until pready is seen at a rising edge
	task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		if (n >= 50) error_cnt++;
		psel <= 0;
		penable <= 0;
	endtask

	task rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
		apb(0, a, 32'h0);
		`CHK(rd, {24'h0, e})
	endtask

	// one-cycle event pulse; flags land at the edge that ends it
	task step(input logic [5:0] t, input logic fd);
		@(posedge pclk);
		tx_ev <= t;
		fdone <= fd;
		@(posedge pclk);
		tx_ev <= 6'h00;
		fdone <= 0;
	endtask

	task settle;
		repeat (2) @(posedge pclk);
		#1;
	endtask

	task wk(input logic [7:0] c, input logic e);
		apb(1, A_C1, {24'h0, c});
		step(6'h00, 1);
		#1;
		`CHK(wake, e)
		rdchk(A_RX, {e, 7'h01});
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		end_of_test();
	end

	initial begin
		int n;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		rdchk(A_C0, 8'h04);
		rdchk(A_C1, 8'h00);
		foreach (rows[i]) begin
			flen <= rows[i].len;
			crc <= rows[i].crc;
			al <= rows[i].al;
			step(rows[i].tx, rows[i].fd);
			rdchk(A_TX, rows[i].txe);
			rdchk(A_RX, rows[i].rxe);
			rdchk(A_TX, 8'h00);
			rdchk(A_RX, 8'h00);
		end
		// ==========================================================
		// endpoint clear, status writes ignored, unmapped access
		rxbf <= 1;
		step(6'h00, 0);
		rxbf <= 0;
		rdchk(A_RX, 8'h40);
		step(6'h08, 0);
		step(6'h00, 1);
		@(posedge pclk);
		iep <= 1;
		@(posedge pclk);
		iep <= 0;
		apb(1, A_TX, 32'hff);
		rdchk(A_TX, 8'h00);
		rdchk(A_RX, 8'h00);
		rdchk(11'h7fc, 8'h00);
		`CHK(err, 1'b1)
		// ==========================================================
		// configuration side effects
		apb(1, A_C0, 32'hff);
		rdchk(A_C0, 8'hcf);
		apb(1, A_C1, 32'hff);
		rdchk(A_C1, 8'h73);
		settle();
		`CHK({phy_off, afe, lamp_out}, {1'b1, 1'b0, lamp_in})
		`CHK({pjoin, pen}, 6'h30)
		apb(1, A_C1, 32'h01);
		apb(1, A_C0, 32'h00);
		settle();
		`CHK({phy_off, on_mii, afe, lamp_out}, 7'h3f)
		`CHK({pjoin, pen}, 6'h1c)
		link <= 1;
		settle();
		`CHK({on_mii, afe}, 2'b00)
		rdchk(A_C0, 8'h00);
		rdchk(A_RX, 8'h20);
		// ==========================================================
		// tuning write gate and eeprom reload
		apb(1, A_TA, 32'h1234);
		settle();
		`CHK(ta, 16'h0000)
		apb(1, A_C0, 32'h40);
		apb(1, A_TA, 32'h1234);
		settle();
		`CHK(ta, 16'h1234)
		apb(1, A_LD, 32'h1);
		apb(0, A_LD, 32'h0);
		`CHK(rd[0], 1'b1)
		n = 0;
		do begin
			apb(0, A_LD, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 20);
		`CHK(rd[0], 1'b0)
		`CHK({ta, tb, tt}, 48'h3c5a_0f1e_7788)
		rdchk(A_C0, 8'h42);
		`CHK(scheme, 2'b10)
		apb(0, {IDX_TUNE_T, 2'b00}, 32'h0);
		`CHK(rd, 32'h0000_7788)
		// ==========================================================
		// wake on frames: matching enable, other enable, host wakeup off
		rwe <= 1;
		flen <= 13'h0064;
		crc <= 0;
		al <= 0;
		for (int k = 0; k < 3; k++) begin
			da <= das[k];
			wk(8'h40 >> k, 1'b1);
			wk(8'h40 >> ((k + 2) % 3), 1'b0);
		end
		hash <= 0;
		da <= das[1];
		wk(8'h20, 1'b0);
		da <= STA;
		rwe <= 0;
		wk(8'h10, 1'b0);
		// ==========================================================
		// reset in mid-run: defaults back, a link already up is no change
		@(posedge pclk);
		presetn <= 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		rdchk(A_C0, 8'h00);
		rdchk(A_RX, 8'h00);
		`CHK({scheme, pjoin, pen, lamp_out}, 12'h0ff)
		end_of_test();
	end
endmodule
